// ===== hw/sofc_pkg.sv
package sofc_pkg;

	// ******************************************************
	// Register map
	// ******************************************************
	localparam logic [7:0] UNLOCK_PIN_AND_REF_DIVIDER_CONFIG_ADDR = 8'h16;
	localparam logic [7:0] OUTPUT_DURING_UNLOCK_CONFIG_ADDR       = 8'h17;
	localparam logic [7:0] DEVICE_CONTROL_ADDR                    = 8'h02;
	localparam logic [7:0] DEVICE_CONFIG_ADDR                     = 8'h03;
	localparam logic [7:0] RATIO_BASE_ADDR                        = 8'h06;
	localparam logic [7:0] RATIO_LAST_ADDR                        = 8'h09;

	// ******************************************************
	// Field positions
	// ******************************************************
	localparam int UNLOCK_PIN_STYLE_BIT     = 6;
	localparam int REF_INPUT_DIVIDER_LSB    = 3;
	localparam int OUTPUT_DURING_UNLOCK_BIT = 4;
	localparam int SECONDARY_PIN_SOURCE_LSB = 1;
	localparam int UNLOCK_STATUS_BIT        = 7;

	// ******************************************************
	// Reset values (none documented; zero chosen)
	// ******************************************************
	localparam logic [7:0]  CFG1_RESET  = 8'h00;
	localparam logic [7:0]  CFG2_RESET  = 8'h00;
	localparam logic [1:0]  SRC_RESET   = 2'h0;
	localparam logic [31:0] RATIO_RESET = 32'h0000_0000;

	// ******************************************************
	// Encodings
	// ******************************************************
	localparam logic [1:0] DIV_BY_4 = 2'h0;
	localparam logic [1:0] DIV_BY_2 = 2'h1;
	localparam logic [1:0] DIV_BY_1 = 2'h2;
	localparam logic [1:0] SRC_REF  = 2'h0;
	localparam logic [1:0] SRC_PLL  = 2'h2;
	localparam logic [1:0] SRC_LOCK = 2'h3;

endpackage : sofc_pkg

// ===== hw/sofc_top.sv
// Operation
// - Unlock pin style applies only when secondary pin shows lock state
// - Style zero: push-pull, high when unlocked, low when locked
// - Style one: open drain, low when unlocked, released when locked
// - Reference divider: 00 by four, 01 by two, 10 by one, 11 reserved
// - Output-during-unlock zero: clock outputs held low while unlocked
// - Output-during-unlock one: clock outputs always enabled
// - First config register at 16h: style bit 6, divider bits 4:3
// - Second config register at 17h: output-during-unlock at bit 4
// - Source: 00 reference, 10 PLL copy, 11 lock indicator, 01 reserved
// - Four byte registers form user ratio, most significant byte first
// - Read-only status bit: one unlocked, zero locked
`timescale 1ns/1ps

module sofc_top
	import sofc_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        arst_n,
	// Register port (synchronous control port decode)
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	output logic             reg_rvalid,
	// Analog PLL side
	input  wire logic        pll_unlocked,
	input  wire logic        pll_clk_in,
	input  wire logic        ref_clk_in,
	// Outputs
	output logic             clk_out,
	output logic             secondary_pin_o,
	output logic             secondary_pin_oe,
	output logic             ref_div_en,
	output logic      [31:0] user_ratio_value
);

	// ******************************************************
	// Reset release and input synchronisers
	// ******************************************************
	logic       rst_s1_q, rst_n_q;
	logic [2:0] in_s1_q, in_s2_q;

	// Reset release through two flops
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_s1_q <= 1'b0;
			rst_n_q  <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q  <= rst_s1_q;
		end
	end

	// Two-flop synchronisers for unlock, PLL clock and reference clock
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			in_s1_q <= 3'h1;
			in_s2_q <= 3'h1;
		end else begin
			in_s1_q <= {ref_clk_in, pll_clk_in, pll_unlocked};
			in_s2_q <= in_s1_q;
		end
	end

	logic unl, pll_c, ref_c;
	assign unl   = in_s2_q[0];
	assign pll_c = in_s2_q[1];
	assign ref_c = in_s2_q[2];

	// ******************************************************
	// Register file
	// ******************************************************
	logic [7:0]  cfg1_q, cfg1_d, cfg2_q, cfg2_d;
	logic [1:0]  src_q, src_d;
	logic [31:0] ratio_q, ratio_d;
	logic [7:0]  rdata_d;
	logic        rvalid_d;

	// Upper bit of the two-bit secondary source field
	localparam int SRC_LSB_HI = SECONDARY_PIN_SOURCE_LSB + 1;

	// Write decode and read mux
	always_comb begin
		cfg1_d   = cfg1_q;
		cfg2_d   = cfg2_q;
		src_d    = src_q;
		ratio_d  = ratio_q;
		rdata_d  = 8'h00;
		rvalid_d = reg_rd;
		if (reg_wr) begin
			if (reg_addr == UNLOCK_PIN_AND_REF_DIVIDER_CONFIG_ADDR) begin
				cfg1_d = reg_wdata;
			end
			if (reg_addr == OUTPUT_DURING_UNLOCK_CONFIG_ADDR) begin
				cfg2_d = reg_wdata;
			end
			if (reg_addr == DEVICE_CONFIG_ADDR) begin
				src_d = reg_wdata[SRC_LSB_HI:SECONDARY_PIN_SOURCE_LSB];
			end
			if (reg_addr >= RATIO_BASE_ADDR && reg_addr <= RATIO_LAST_ADDR) begin
				ratio_d = put_byte(ratio_q, reg_addr - RATIO_BASE_ADDR,
					reg_wdata);
			end
		end
		if (reg_rd) begin
			unique case (reg_addr)
				UNLOCK_PIN_AND_REF_DIVIDER_CONFIG_ADDR: rdata_d = cfg1_q;
				OUTPUT_DURING_UNLOCK_CONFIG_ADDR:       rdata_d = cfg2_q;
				DEVICE_CONTROL_ADDR:
					rdata_d = {unl, 7'h00};
				DEVICE_CONFIG_ADDR:
					rdata_d = {5'h00, src_q, 1'b0};
				8'h06, 8'h07, 8'h08, 8'h09:
					rdata_d = get_byte(ratio_q, reg_addr - RATIO_BASE_ADDR);
				default: rdata_d = 8'h00;
			endcase
		end
	end

	// Byte index 0 is the most significant byte
	function automatic logic [31:0] put_byte(input logic [31:0] v,
		input logic [7:0] idx, input logic [7:0] b);
		logic [31:0] r;
		r = v;
		r[8*(3-idx[1:0]) +: 8] = b;
		return r;
	endfunction : put_byte

	function automatic logic [7:0] get_byte(input logic [31:0] v,
		input logic [7:0] idx);
		return v[8*(3-idx[1:0]) +: 8];
	endfunction : get_byte

	// Register storage
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			cfg1_q     <= CFG1_RESET;
			cfg2_q     <= CFG2_RESET;
			src_q      <= SRC_RESET;
			ratio_q    <= RATIO_RESET;
			reg_rdata  <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			cfg1_q     <= cfg1_d;
			cfg2_q     <= cfg2_d;
			src_q      <= src_d;
			ratio_q    <= ratio_d;
			reg_rdata  <= rdata_d;
			reg_rvalid <= rvalid_d;
		end
	end

	// ******************************************************
	// Reference divider enable
	// ******************************************************
	logic [1:0] div_cnt_q, div_cnt_d;
	logic       ref_prev_q, ref_en_d;
	logic [1:0] div_sel;
	assign div_sel = cfg1_q[REF_INPUT_DIVIDER_LSB +: 2];

	// One pulse per one, two or four reference rising edges
	always_comb begin
		div_cnt_d = div_cnt_q;
		ref_en_d  = 1'b0;
		if (ref_c && !ref_prev_q) begin
			div_cnt_d = div_cnt_q + 2'h1;
			unique case (div_sel)
				DIV_BY_4: ref_en_d = (div_cnt_q == 2'h3);
				DIV_BY_2: ref_en_d = div_cnt_q[0];
				DIV_BY_1: ref_en_d = 1'b1;
				default:  ref_en_d = 1'b0; // Reserved code: no pulses
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			div_cnt_q  <= 2'h0;
			ref_prev_q <= 1'b0;
			ref_div_en <= 1'b0;
		end else begin
			div_cnt_q  <= div_cnt_d;
			ref_prev_q <= ref_c;
			ref_div_en <= ref_en_d;
		end
	end

	// ******************************************************
	// Output gating and secondary pin
	// ******************************************************
	logic clk_out_d, sec_o_d, sec_oe_d;

	always_comb begin
		// Gate clock low on unlock unless kept running
		clk_out_d = (unl && !cfg2_q[OUTPUT_DURING_UNLOCK_BIT])
			? 1'b0 : pll_c;
		sec_oe_d = 1'b1;
		unique case (src_q)
			SRC_REF: sec_o_d = ref_c;
			SRC_PLL: sec_o_d = clk_out_d;
			SRC_LOCK: begin
				if (cfg1_q[UNLOCK_PIN_STYLE_BIT]) begin
					sec_o_d  = 1'b0;
					sec_oe_d = unl;
				end else begin
					sec_o_d = unl;
				end
			end
			default: sec_o_d = 1'b0; // Reserved source drives low
		endcase
	end

	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			clk_out          <= 1'b0;
			secondary_pin_o  <= 1'b0;
			secondary_pin_oe <= 1'b0;
			user_ratio_value <= RATIO_RESET;
		end else begin
			clk_out          <= clk_out_d;
			secondary_pin_o  <= sec_o_d;
			secondary_pin_oe <= sec_oe_d;
			user_ratio_value <= ratio_q;
		end
	end

endmodule : sofc_top

// ===== sim/sofc_pll_model.sv
`timescale 1ns/1ps
module sofc_pll_model (
	input  wire logic want_unl,
	output logic      pll_unlocked, pll_clk_in, ref_clk_in
);
	// Analog side clocks, free-running and unrelated to clk
	initial {pll_clk_in, ref_clk_in} = 2'h0;
	always #13 pll_clk_in = ~pll_clk_in;
	always #20 ref_clk_in = ~ref_clk_in;
	// Lock state, one while unlocked
	assign pll_unlocked = want_unl;
endmodule : sofc_pll_model

// ===== sim/sofc_top_asserts.sv
`timescale 1ns/1ps
module sofc_top_asserts (
	// Clock, reset and register port
	input wire logic        clk, arst_n, reg_wr, reg_rd, reg_rvalid,
	input wire logic [7:0]  reg_addr, reg_wdata, reg_rdata,
	// Lock input and outputs
	input wire logic        pll_unlocked, clk_out, ref_div_en,
	input wire logic        secondary_pin_o, secondary_pin_oe,
	input wire logic [31:0] user_ratio_value
);
	logic [7:0] c1_q, c2_q, s_q;
	logic [2:0] n_q;
	logic       q, lk;
	// Written config, and cycles since the last write
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			{c1_q, c2_q, s_q, n_q} <= 27'h0;
		end else begin
			n_q <= reg_wr ? 3'h0 : n_q + 3'(n_q != 3'h7);
			if (reg_wr && reg_addr == 8'h16) c1_q <= reg_wdata;
			if (reg_wr && reg_addr == 8'h17) c2_q <= reg_wdata;
			if (reg_wr && reg_addr == 8'h03) s_q <= reg_wdata;
		end
	end
	// Settled state; pin used as lock indicator
	assign q = n_q == 3'h7;
	assign lk = q && s_q[2:1] == 2'h3;
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	rd_ans_a: assert property (reg_rd |=> reg_rvalid)
		else $error("no answer");
	no_rv_a: assert property (!reg_rd |=> !reg_rvalid)
		else $error("stray answer");
	cfg1_rd_a: assert property (reg_rd && reg_addr == 8'h16
		|=> reg_rdata == c1_q) else $error("cfg1 read");
	pp_pin_a: assert property (lk && !c1_q[6] |-> secondary_pin_oe
		&& secondary_pin_o == $past(pll_unlocked, 3)) else $error("pin");
	od_pin_a: assert property (lk && c1_q[6] |-> !(secondary_pin_o
		&& secondary_pin_oe) && secondary_pin_oe == $past(pll_unlocked, 3))
		else $error("pin");
	clk_gate_a: assert property (q && !c2_q[4] && $past(pll_unlocked, 3)
		|-> !clk_out) else $error("clock not held low");
	div_gap_a: assert property (q && c1_q[4:3] == 2'h0 && ref_div_en
		|=> !ref_div_en [*7]) else $error("divider pulse");
	ratio_load_a: assert property (reg_wr && reg_addr == 8'h09 |-> ##2
		user_ratio_value[7:0] == $past(reg_wdata, 2)) else $error("ratio");
	// Main scenarios reached
	cover property (lk && c1_q[6] && pll_unlocked);
	cover property (q && !c2_q[4] && pll_unlocked);
	cover property (q && c1_q[4:3] == 2'h2 && ref_div_en);
endmodule : sofc_top_asserts
bind sofc_top sofc_top_asserts u_chk (.*);

// ===== sim/sofc_top_tb.sv
`timescale 1ns/1ps
module sofc_top_tb;
	logic clk, arst_n, reg_wr, reg_rd, reg_rvalid, want_unl, clk_out;
	logic pll_unlocked, pll_clk_in, ref_clk_in, ref_div_en;
	logic secondary_pin_o, secondary_pin_oe;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [31:0] user_ratio_value, h, c[3];
	int n_errors, num_checks;
	sofc_pll_model pll (.*);
	sofc_top dut (.*);
	// Clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Compare and count
	task automatic chk(string s, logic [31:0] e, g);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s exp %h got %h", s, e, g);
		end
	endtask : chk
	// Register access; read data lands in h
	task automatic wr(logic [7:0] a, d);
		@(negedge clk);
		{reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
		@(negedge clk);
		reg_wr = 1'b0;
	endtask : wr
	task automatic rd(logic [7:0] a);
		@(negedge clk);
		{reg_rd, reg_addr} = {1'b1, a};
		@(negedge clk);
		reg_rd = 1'b0;
		h = {24'h0, reg_rdata};
		chk("rvalid", 1, reg_rvalid);
	endtask : rd
	// Wait n cycles, counting high samples of s
	task automatic run(int n, ref logic s, output logic [31:0] k);
		k = 32'h0;
		repeat (n) begin
			@(negedge clk);
			k += s;
		end
	endtask : run
	task tally_and_finish;
		$display("%0d checks, %0d errors", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish
	// Main sequence
	initial begin
		{arst_n, reg_wr, reg_rd, want_unl, reg_addr, reg_wdata} = 20'h0;
		run(8, clk_out, h);
		arst_n = 1'b1;
		run(2, clk_out, h);
		wr(8'h16, 8'h50);
		rd(8'h16);
		chk("cfg1", 8'h50, h);
		wr(8'h17, 8'h10);
		rd(8'h17);
		chk("cfg2", 8'h10, h);
		rd(8'h40);
		chk("unmapped", 0, h);
		for (int k = 0; k < 3; k++) begin
			wr(8'h16, 8'(k << 3));
			run(400, ref_div_en, c[k]);
		end
		chk("div_by4", 1, c[0] inside {[9:11]});
		chk("div_by2", 1, c[1] inside {[19:21]});
		chk("div_rate", 1, c[2] inside {[39:41]});
		$display("register and divider test done");
		wr(8'h03, 8'h06);
		for (int s = 0; s < 2; s++) begin
			wr(8'h16, 8'(s << 6));
			for (int u = 0; u < 2; u++) begin
				want_unl = u[0];
				run(6, clk_out, h);
				chk("pin_oe", s ? u : 1, secondary_pin_oe);
				chk("pin", s ? 0 : u, secondary_pin_o & secondary_pin_oe);
			end
		end
		wr(8'h17, 8'h00);
		run(100, clk_out, h);
		chk("gated", 0, h);
		rd(8'h02);
		chk("unlock", 1, h[7]);
		wr(8'h17, 8'h10);
		run(100, clk_out, h);
		chk("running", 1, h > 0);
		want_unl = 1'b0;
		wr(8'h03, 8'h00);
		run(6, clk_out, h);
		chk("pin_clk_oe", 1, secondary_pin_oe);
		for (int i = 0; i < 4; i++)
			wr(8'h06 + 8'(i), 8'(32'h0013a92a >> (24 - 8 * i)));
		run(3, clk_out, h);
		chk("ratio", 32'h0013a92a, user_ratio_value);
		rd(8'h07);
		chk("ratio_rd", 8'h13, h);
		$display("pin and output test done");
		tally_and_finish();
	end
endmodule : sofc_top_tb
